// ---- common/serial_port_pkg.sv ----
package serial_port_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ------------------------------------------------------------
	localparam logic [11:0] SERIAL_BUFFER_ADDR = 12'h000;
	localparam logic [11:0] SERIAL_CONTROL_ADDR = 12'h004;
	localparam logic [11:0] POWER_CONTROL_ADDR = 12'h008;
	localparam logic [11:0] BAUD_RELOAD_ADDR = 12'h00c;
	localparam logic [11:0] STATUS_ADDR = 12'h010;

	// ------------------------------------------------------------
	// serial_control field positions; BAUD_DOUBLE_POS is in power_control_reg
	// ------------------------------------------------------------
	localparam int RX_DONE_POS = 0;
	localparam int TX_DONE_POS = 1;
	localparam int RX_NINTH_POS = 2;
	localparam int TX_NINTH_POS = 3;
	localparam int RX_ENABLE_POS = 4;
	localparam int MULTIPROC_POS = 5;
	localparam int MODE_LOW_POS = 6;
	localparam int MODE_HIGH_POS = 7;
	localparam int BAUD_DOUBLE_POS = 7;

	// ------------------------------------------------------------
	// reset values and timing counts
	// ------------------------------------------------------------
	localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	localparam logic [15:0] BAUD_RELOAD_RESET = 16'hfff0;
	localparam logic [3:0] SLICE_LAST = 4'hf;
	localparam logic [3:0] SLICE_VOTE_A = 4'h7;
	localparam logic [3:0] SLICE_VOTE_B = 4'h8;
	localparam logic [3:0] SLICE_VOTE_C = 4'h9;
	localparam logic [3:0] SLICE_TX_DRIVE = 4'h0;
	localparam logic [3:0] TX_BITS_MODE1 = 4'h9;
	localparam logic [3:0] TX_BITS_MODE23 = 4'ha;
	localparam logic [3:0] RX_BITS_MODE1 = 4'h9;
	localparam logic [3:0] RX_BITS_MODE23 = 4'ha;
	localparam logic [1:0] OSC_PER_TICK_FAST = 2'h1;
	localparam logic [1:0] OSC_PER_TICK_SLOW = 2'h3;

	typedef enum logic [1:0]
	{
		MODE_SYNC = 2'b00,
		MODE_TEN_BIT = 2'b01,
		MODE_ELEVEN_FIXED = 2'b10,
		MODE_ELEVEN_TIMER = 2'b11
	} serial_mode_type;

	typedef enum logic [1:0]
	{
		RX_HUNT = 2'b00,
		RX_START = 2'b01,
		RX_SHIFT = 2'b10
	} rx_state_type;

	typedef struct packed
	{
		logic [7:0] data;
		logic ninth;
	} serial_word_type;

endpackage : serial_port_pkg

// ---- verilog/async_serial_port.sv ----
// Operation
// - mode 1 frame: zero start, eight data lsb first, one stop bit.
// - mode 1 accepted frame stores its stop bit in rx_ninth_bit.
// - mode 1 rate is timer overflow over 16 or 32, set by baud_double_bit.
// - each tx bit driven at state6_phase2 after divider rollover, not at write.
// - mode 1 tx_done_flag set as stop bit starts, tenth rollover after write.
// - modes 2 and 3 tx_done_flag set at eleventh rollover after write.
// - receive only with receive enable high; start on falling rx edge.
// - edge detector samples at 16x baud, resets divider at once on edge.
// - each bit is a 2-of-3 vote at slices 7, 8 and 9.
// - start bit voted nonzero aborts reception and resumes edge hunt.
// - load buffer, set rx_done_flag only if flag clear and check passes.
// - modes 2 and 3 shift nine bits then one more before loading.
// - after middle of stop bit, receiver returns to edge hunting.
// - modes 2 and 3 frame: start, eight data, tx_ninth_bit, stop.
// - modes 2 and 3 store received ninth bit in rx_ninth_bit.
// - mode 2 rate is oscillator over 32 or 64 by baud_double_bit.
// - mode 3 equals mode 2 but rate comes from timer overflow.
// - mode bits: 00 sync, 01 ten-bit, 10 eleven fixed, 11 eleven timer.
// - any write to serial_buffer starts a transmission; here writes in mode 0 (sync) start none.
// - buffer writes go to transmit register, reads from receive buffer.
//
// Chosen here: register access over APB and the address map.
module async_serial_port
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd
);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic wr_access;
	logic rd_access;
	logic wr_buffer;
	logic wr_control;
	logic addr_valid;

	assign pready = 1'b1;
	assign wr_access = psel & penable & pwrite;
	assign rd_access = psel & penable & ~pwrite;
	assign addr_valid = (paddr == serial_port_pkg::SERIAL_BUFFER_ADDR)
		| (paddr == serial_port_pkg::SERIAL_CONTROL_ADDR)
		| (paddr == serial_port_pkg::POWER_CONTROL_ADDR)
		| (paddr == serial_port_pkg::BAUD_RELOAD_ADDR)
		| (paddr == serial_port_pkg::STATUS_ADDR);
	assign pslverr = psel & penable & ~addr_valid;
	assign wr_buffer = wr_access
		& (paddr == serial_port_pkg::SERIAL_BUFFER_ADDR);
	assign wr_control = wr_access
		& (paddr == serial_port_pkg::SERIAL_CONTROL_ADDR);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] control_reg, control_next;
	logic [7:0] power_control_reg, power_control_next;
	logic [15:0] reload_reg, reload_next;
	logic [7:0] rx_buffer_reg, rx_buffer_next;
	logic [8:0] tx_shift_reg, tx_shift_next;
	logic [3:0] tx_count_reg, tx_count_next;
	logic tx_busy_reg, tx_busy_next;
	logic tx_pending_reg, tx_pending_next;
	logic txd_reg, txd_next;
	logic [15:0] timer_reg, timer_next;
	logic [1:0] osc_div_reg, osc_div_next;
	logic half_reg, half_next;
	logic [3:0] tx_slice_reg, tx_slice_next;
	logic [3:0] rx_slice_reg, rx_slice_next;
	serial_port_pkg::rx_state_type rx_state_reg, rx_state_next;
	logic [3:0] rx_count_reg, rx_count_next;
	logic [8:0] rx_shift_reg, rx_shift_next;
	logic [2:0] vote_reg, vote_next;
	logic rxd_last_reg, rxd_last_next;

	serial_port_pkg::serial_mode_type mode;
	logic tick16;
	logic timer_ovf;
	logic tx_roll;
	logic tx_done_set;
	logic rx_done_set;
	logic rx_ninth_set;
	logic rx_ninth_val;
	logic rx_abort;
	logic voted;
	logic eleven;

	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : majority

	assign mode = serial_port_pkg::serial_mode_type'({
		control_reg[serial_port_pkg::MODE_HIGH_POS],
		control_reg[serial_port_pkg::MODE_LOW_POS]});
	assign eleven = control_reg[serial_port_pkg::MODE_HIGH_POS];
	assign voted = majority(vote_reg);

	// ------------------------------------------------------------
	// baud tick generation at 16x the bit rate
	// ------------------------------------------------------------
	// the timer stands in for the overflow source of modes 1 and 3;
	// the halving stage gives the 1/16 or 1/32 choice by baud_double_bit
	always_comb
	begin
		timer_next = timer_reg + 16'h0001;
		timer_ovf = 1'b0;
		if (timer_reg == 16'hffff)
		begin
			timer_next = reload_reg;
			timer_ovf = 1'b1;
		end
		osc_div_next = osc_div_reg + 2'h1;
		half_next = half_reg;
		tick16 = 1'b0;
		if (mode == serial_port_pkg::MODE_ELEVEN_FIXED)
		begin
			// fixed clock: 1/32 or 1/64 of pclk as the bit rate
			if (osc_div_reg == (power_control_reg[
				serial_port_pkg::BAUD_DOUBLE_POS] ?
				serial_port_pkg::OSC_PER_TICK_FAST :
				serial_port_pkg::OSC_PER_TICK_SLOW))
			begin
				osc_div_next = 2'h0;
				tick16 = 1'b1;
			end
		end
		else if (timer_ovf)
		begin
			half_next = ~half_reg;
			tick16 = power_control_reg[serial_port_pkg::BAUD_DOUBLE_POS]
				| half_reg;
		end
	end

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	always_comb
	begin
		tx_slice_next = tx_slice_reg;
		tx_roll = 1'b0;
		if (tick16)
		begin
			tx_slice_next = tx_slice_reg + 4'h1;
			tx_roll = (tx_slice_reg == serial_port_pkg::SLICE_LAST);
		end
		tx_shift_next = tx_shift_reg;
		tx_count_next = tx_count_reg;
		tx_busy_next = tx_busy_reg;
		tx_pending_next = tx_pending_reg;
		txd_next = txd_reg;
		tx_done_set = 1'b0;
		if (wr_buffer && mode != serial_port_pkg::MODE_SYNC)
		begin
			// ninth slot is tx_ninth_bit in modes 2/3, stop in mode 1
			tx_shift_next = {eleven ?
				control_reg[serial_port_pkg::TX_NINTH_POS] : 1'b1,
				pwdata[7:0]};
			tx_count_next = 4'h0;
			tx_pending_next = 1'b1;
			tx_busy_next = 1'b0;
		end
		else if (tx_roll && (tx_pending_reg || tx_busy_reg))
		begin
			// bits move only on divider rollover
			tx_pending_next = 1'b0;
			tx_busy_next = 1'b1;
			tx_count_next = tx_count_reg + 4'h1;
			if (tx_count_reg == 4'h0)
			begin
				txd_next = 1'b0;
			end
			else if (tx_count_reg == (eleven ?
				serial_port_pkg::TX_BITS_MODE23 :
				serial_port_pkg::TX_BITS_MODE1))
			begin
				txd_next = 1'b1;
				tx_done_set = 1'b1;
				tx_busy_next = 1'b0;
			end
			else
			begin
				txd_next = tx_shift_reg[0];
				tx_shift_next = {1'b1, tx_shift_reg[8:1]};
			end
		end
	end

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	always_comb
	begin
		rx_state_next = rx_state_reg;
		rx_slice_next = rx_slice_reg;
		rx_count_next = rx_count_reg;
		rx_shift_next = rx_shift_reg;
		vote_next = vote_reg;
		rxd_last_next = rxd_last_reg;
		rx_buffer_next = rx_buffer_reg;
		rx_done_set = 1'b0;
		rx_ninth_set = 1'b0;
		rx_ninth_val = 1'b0;
		rx_abort = 1'b0;
		if (tick16)
		begin
			rxd_last_next = rxd;
			rx_slice_next = rx_slice_reg + 4'h1;
			if (rx_slice_reg == serial_port_pkg::SLICE_VOTE_A)
				vote_next[0] = rxd;
			if (rx_slice_reg == serial_port_pkg::SLICE_VOTE_B)
				vote_next[1] = rxd;
			if (rx_slice_reg == serial_port_pkg::SLICE_VOTE_C)
				vote_next[2] = rxd;
		end
		unique case (rx_state_reg)
			serial_port_pkg::RX_HUNT:
			begin
				if (tick16 && rxd_last_reg && !rxd
					&& control_reg[serial_port_pkg::RX_ENABLE_POS]
					&& mode != serial_port_pkg::MODE_SYNC)
				begin
					rx_slice_next = 4'h0;
					rx_count_next = 4'h0;
					rx_state_next = serial_port_pkg::RX_START;
				end
			end
			serial_port_pkg::RX_START:
			begin
				if (tick16 && rx_slice_reg == serial_port_pkg::SLICE_VOTE_C)
				begin
					if (majority({rxd, vote_reg[1:0]}))
					begin
						rx_abort = 1'b1;
						rx_state_next = serial_port_pkg::RX_HUNT;
					end
					else
						rx_state_next = serial_port_pkg::RX_SHIFT;
				end
			end
			serial_port_pkg::RX_SHIFT:
			begin
				if (tick16 && rx_slice_reg == serial_port_pkg::SLICE_VOTE_C)
				begin
					rx_shift_next = {majority({rxd, vote_reg[1:0]}),
						rx_shift_reg[8:1]};
					rx_count_next = rx_count_reg + 4'h1;
					if (rx_count_reg == (eleven ?
						serial_port_pkg::RX_BITS_MODE23 :
						serial_port_pkg::RX_BITS_MODE1) - 4'h1)
					begin
						// last shift is the stop bit
						rx_state_next = serial_port_pkg::RX_HUNT;
						if (!control_reg[serial_port_pkg::RX_DONE_POS]
							&& (!control_reg[serial_port_pkg::MULTIPROC_POS]
							|| majority({rxd, vote_reg[1:0]})))
						begin
							rx_done_set = 1'b1;
							rx_ninth_set = 1'b1;
							if (eleven)
							begin
								rx_buffer_next = rx_shift_reg[7:0];
								rx_ninth_val = rx_shift_reg[8];
							end
							else
							begin
								rx_buffer_next = rx_shift_reg[8:1];
								rx_ninth_val = majority({rxd,
									vote_reg[1:0]});
							end
						end
					end
				end
			end
			default:
				rx_state_next = serial_port_pkg::RX_HUNT;
		endcase
	end

	// ------------------------------------------------------------
	// software registers; hardware set wins over a software clear
	// ------------------------------------------------------------
	always_comb
	begin
		control_next = control_reg;
		power_control_next = power_control_reg;
		reload_next = reload_reg;
		if (wr_control)
			control_next = pwdata[7:0];
		if (wr_access && paddr == serial_port_pkg::POWER_CONTROL_ADDR)
			power_control_next = pwdata[7:0];
		if (wr_access && paddr == serial_port_pkg::BAUD_RELOAD_ADDR)
			reload_next = pwdata[15:0];
		if (tx_done_set)
			control_next[serial_port_pkg::TX_DONE_POS] = 1'b1;
		if (rx_done_set)
			control_next[serial_port_pkg::RX_DONE_POS] = 1'b1;
		if (rx_ninth_set)
			control_next[serial_port_pkg::RX_NINTH_POS] = rx_ninth_val;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control_reg <= serial_port_pkg::SERIAL_CONTROL_RESET;
			power_control_reg <= serial_port_pkg::POWER_CONTROL_RESET;
			reload_reg <= serial_port_pkg::BAUD_RELOAD_RESET;
			rx_buffer_reg <= 8'h00;
			tx_shift_reg <= 9'h1ff;
			tx_count_reg <= 4'h0;
			tx_busy_reg <= 1'b0;
			tx_pending_reg <= 1'b0;
			txd_reg <= 1'b1;
			// start at the reload so the first overflow is not 64k away
			timer_reg <= serial_port_pkg::BAUD_RELOAD_RESET;
			osc_div_reg <= 2'h0;
			half_reg <= 1'b0;
			tx_slice_reg <= 4'h0;
			rx_slice_reg <= 4'h0;
			rx_state_reg <= serial_port_pkg::RX_HUNT;
			rx_count_reg <= 4'h0;
			rx_shift_reg <= 9'h000;
			vote_reg <= 3'h0;
			rxd_last_reg <= 1'b1;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			control_reg <= control_next;
			power_control_reg <= power_control_next;
			reload_reg <= reload_next;
			rx_buffer_reg <= rx_buffer_next;
			tx_shift_reg <= tx_shift_next;
			tx_count_reg <= tx_count_next;
			tx_busy_reg <= tx_busy_next;
			tx_pending_reg <= tx_pending_next;
			txd_reg <= txd_next;
			timer_reg <= timer_next;
			osc_div_reg <= osc_div_next;
			half_reg <= half_next;
			tx_slice_reg <= tx_slice_next;
			rx_slice_reg <= rx_slice_next;
			rx_state_reg <= rx_state_next;
			rx_count_reg <= rx_count_next;
			rx_shift_reg <= rx_shift_next;
			vote_reg <= vote_next;
			rxd_last_reg <= rxd_last_next;
			// read data registered in setup so it is valid in access
			if (psel && !penable && !pwrite)
			begin
				unique case (paddr)
					serial_port_pkg::SERIAL_BUFFER_ADDR:
						prdata <= {24'h00_0000, rx_buffer_reg};
					serial_port_pkg::SERIAL_CONTROL_ADDR:
						prdata <= {24'h00_0000, control_reg};
					serial_port_pkg::POWER_CONTROL_ADDR:
						prdata <= {24'h00_0000, power_control_reg};
					serial_port_pkg::BAUD_RELOAD_ADDR:
						prdata <= {16'h0000, reload_reg};
					serial_port_pkg::STATUS_ADDR:
						prdata <= {28'h000_0000, rx_state_reg,
							tx_busy_reg | tx_pending_reg, txd_reg};
					default:
						prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign txd = txd_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking check_clock @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_tx_start_low: assert property (
		tx_roll && tx_pending_reg && !wr_buffer |=> !txd)
		else $error("start bit not low");
	a_tx_done_stop: assert property (
		tx_done_set |=> txd && control_reg[serial_port_pkg::TX_DONE_POS])
		else $error("done without stop bit");
	a_tx_done_count: assert property (
		tx_done_set |-> tx_count_reg == (eleven ?
		serial_port_pkg::TX_BITS_MODE23 : serial_port_pkg::TX_BITS_MODE1))
		else $error("done at wrong rollover");
	a_tx_on_roll: assert property (
		$changed(txd) |-> $past(tx_roll))
		else $error("txd moved off rollover");
	a_rx_enable_gate: assert property (
		rx_state_reg == serial_port_pkg::RX_HUNT
		&& !control_reg[serial_port_pkg::RX_ENABLE_POS]
		|=> rx_state_reg == serial_port_pkg::RX_HUNT)
		else $error("receive while disabled");
	a_rx_edge_reset: assert property (
		rx_state_reg == serial_port_pkg::RX_HUNT
		&& rx_state_next == serial_port_pkg::RX_START
		|=> rx_slice_reg == 4'h0)
		else $error("divider not reset on edge");
	a_rx_abort_hunt: assert property (
		rx_abort |=> rx_state_reg == serial_port_pkg::RX_HUNT)
		else $error("abort did not return to hunt");
	a_rx_flag_hold: assert property (
		control_reg[serial_port_pkg::RX_DONE_POS] && !wr_control
		|=> control_reg[serial_port_pkg::RX_DONE_POS])
		else $error("receive flag dropped by hardware");
	a_rx_no_overrun: assert property (
		control_reg[serial_port_pkg::RX_DONE_POS] |-> !rx_done_set)
		else $error("load while flag set");

endmodule : async_serial_port

// ---- sim/remote_serial_model.sv ----
module remote_serial_model
(
	input wire logic pclk,
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	// the line idles high, so it goes back there after every frame
	initial rxd = 1'b1;

	// bits holds everything after the start bit, first sent in bit 0
	task automatic send_frame(input logic [9:0] bits, input int nbits,
		input int period);
		@(posedge pclk);
		rxd <= 1'b0;
		repeat (period) @(posedge pclk);
		for (int i = 0; i < nbits; i++)
		begin
			rxd <= bits[i];
			repeat (period) @(posedge pclk);
		end
		rxd <= 1'b1;
		repeat (period) @(posedge pclk);
	endtask : send_frame

	// a low pulse far shorter than half a bit: a false start
	task automatic send_glitch();
		@(posedge pclk);
		rxd <= 1'b0;
		repeat (3) @(posedge pclk);
		rxd <= 1'b1;
	endtask : send_glitch

	// width is the start bit length in cycles; data lsb must be one
	task automatic capture(input int nbits, input int period,
		output logic [9:0] bits, output int width, output bit timed_out);
		int n;
		bits = '0;
		width = 0;
		n = 0;
		timed_out = 1'b0;
		while (txd !== 1'b0 && n < 20000)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000)
			timed_out = 1'b1;
		else
		begin
			while (txd === 1'b0 && width < 4 * period)
			begin
				@(posedge pclk);
				width++;
			end
			repeat (period / 2) @(posedge pclk);
			for (int i = 0; i < nbits; i++)
			begin
				bits[i] = txd;
				if (i < nbits - 1)
					repeat (period) @(posedge pclk);
			end
		end
	endtask : capture
endmodule : remote_serial_model

// ---- sim/async_serial_port_modes_bench.sv ----
module async_serial_port_modes_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxd;
	logic txd;
	int bad_count;
	int cmp_count;

	async_serial_port async_serial_port_i
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.rxd(rxd),
		.txd(txd)
	);

	remote_serial_model remote_serial_model_i
	(
		.pclk(pclk),
		.txd(txd),
		.rxd(rxd)
	);

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// reporting and bus access
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// entered just after a rising edge; holds the request until pready
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 16)
		begin
			bad_count++;
			complete_run();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask : rd

	task automatic setup(input logic [7:0] c, input logic [7:0] p,
		input logic [15:0] rl);
		wr(serial_port_pkg::SERIAL_CONTROL_ADDR, {24'h0, c});
		wr(serial_port_pkg::POWER_CONTROL_ADDR, {24'h0, p});
		wr(serial_port_pkg::BAUD_RELOAD_ADDR, {16'h0, rl});
		// a new reload only lands at the next timer overflow
		repeat (300) @(posedge pclk);
	endtask : setup

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		logic [31:0] r;
		logic e;
		rd(serial_port_pkg::SERIAL_CONTROL_ADDR, r);
		chk("control reset", 32'h0000_0000, r);
		rd(serial_port_pkg::BAUD_RELOAD_ADDR, r);
		chk("reload reset", 32'h0000_fff0, r);
		rd(serial_port_pkg::POWER_CONTROL_ADDR, r);
		chk("power reset", 32'h0000_0000, r);
		apb(1'b0, 12'h020, 32'h0000_0000, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0000_0000, r);
	endtask : test_reset

	task automatic tx_case(input logic [7:0] c, input logic [7:0] p,
		input logic [15:0] rl, input logic [7:0] d, input int nb,
		input int per);
		logic [9:0] bits;
		logic [9:0] exp;
		logic [31:0] r;
		int w;
		bit to;
		setup(c, p, rl);
		wr(serial_port_pkg::SERIAL_BUFFER_ADDR, {24'h0, d});
		remote_serial_model_i.capture(nb, per, bits, w, to);
		if (to)
		begin
			bad_count++;
			complete_run();
		end
		exp = c[7] ? {1'b1, c[3], d} : {2'b01, d};
		chk("frame bits", {22'h0, exp}, {22'h0, bits});
		chk("bit period", per, w);
		rd(serial_port_pkg::SERIAL_CONTROL_ADDR, r);
		chk("tx done", 32'h1, {31'h0, r[1]});
		repeat (3 * per) @(posedge pclk);
		rd(serial_port_pkg::SERIAL_CONTROL_ADDR, r);
		chk("tx done held", 32'h1, {31'h0, r[1]});
	endtask : tx_case

	task automatic test_tx_modes();
		tx_case(8'h88, 8'h80, 16'hfff0, 8'ha5, 10, 32);
		tx_case(8'h80, 8'h00, 16'hfff0, 8'h5b, 10, 64);
		tx_case(8'h40, 8'h80, 16'hfffc, 8'hc3, 9, 64);
		tx_case(8'hc8, 8'h00, 16'hfffc, 8'h37, 10, 128);
	endtask : test_tx_modes

	task automatic rx_check(input logic [2:0] fl, input logic [7:0] d);
		logic [31:0] r;
		rd(serial_port_pkg::SERIAL_CONTROL_ADDR, r);
		chk("rx done and ninth", {29'h0, fl}, {29'h0, r[2], 1'b0, r[0]});
		rd(serial_port_pkg::SERIAL_BUFFER_ADDR, r);
		chk("rx buffer", {24'h0, d}, r);
	endtask : rx_check

	task automatic test_rx();
		setup(8'h90, 8'h80, 16'hfff0);
		remote_serial_model_i.send_frame(10'h33c, 10, 32);
		rx_check(3'b101, 8'h3c);
		remote_serial_model_i.send_frame(10'h381, 10, 32);
		rx_check(3'b101, 8'h3c);
		wr(serial_port_pkg::SERIAL_CONTROL_ADDR, 32'h0000_0090);
		remote_serial_model_i.send_glitch();
		repeat (400) @(posedge pclk);
		rx_check(3'b000, 8'h3c);
		remote_serial_model_i.send_frame(10'h296, 10, 32);
		rx_check(3'b001, 8'h96);
		setup(8'h70, 8'h80, 16'hfffc);
		remote_serial_model_i.send_frame(10'h05a, 9, 64);
		rx_check(3'b000, 8'h96);
		remote_serial_model_i.send_frame(10'h1e1, 9, 64);
		rx_check(3'b101, 8'he1);
		setup(8'h80, 8'h80, 16'hfff0);
		remote_serial_model_i.send_frame(10'h3c3, 10, 32);
		rx_check(3'b000, 8'he1);
	endtask : test_rx

	task automatic test_mode0();
		logic low_seen;
		low_seen = 1'b0;
		setup(8'h00, 8'h80, 16'hfff0);
		wr(serial_port_pkg::SERIAL_BUFFER_ADDR, 32'h0000_0055);
		repeat (400)
		begin
			@(posedge pclk);
			low_seen = low_seen | (txd !== 1'b1);
		end
		chk("sync mode line idle", 32'h0, {31'h0, low_seen});
	endtask : test_mode0

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		bad_count = 0;
		cmp_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_reset();
		test_tx_modes();
		test_rx();
		test_mode0();
		complete_run();
	end
endmodule : async_serial_port_modes_bench
